// ### logic/llc_hdr_pkg.sv
// Constants, types and helper functions of the frame header codec
////////////////////////////////////////////////////////////////////////////////
package llc_hdr_pkg;

    localparam int        CLK_PERIOD_NS  = 25;
    localparam int        TS_UNIT_NS     = 10;
    localparam logic [32:0] TS_HALF_STEP = 33'(2 * CLK_PERIOD_NS / TS_UNIT_NS);
    localparam logic [3:0] HDR_SHORT_LEN = 4'h6;
    localparam logic [3:0] HDR_LONG_LEN  = 4'ha;
    localparam logic [2:0] PRIO_MGMT     = 3'h7;
    localparam logic [2:0] PRIO_NONE     = 3'h0;
    localparam logic [7:0] SRC_INTER     = 8'hfb;
    localparam logic [5:0] HOP_ONE       = 6'h01;

    // Register byte addresses
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_TXCFG  = 12'h004;
    localparam logic [11:0] ADDR_TXNODE = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    localparam logic [11:0] ADDR_RXCFG  = 12'h010;
    localparam logic [11:0] ADDR_RXNODE = 12'h014;
    localparam logic [11:0] ADDR_RXTIME = 12'h018;
    localparam logic [11:0] ADDR_THR    = 12'h01c;
    localparam logic [11:0] ADDR_NOW    = 12'h020;

    // Control and status bits
    localparam int CTRL_START = 0;
    localparam int CTRL_RELAY = 1;
    localparam int CTRL_INTER = 2;
    localparam int ST_BUSY    = 0;
    localparam int ST_RXDONE  = 1;
    localparam int ST_DROP    = 2;
    localparam int ST_ABOVE   = 3;

    typedef enum logic [2:0] {
        FT_PAD  = 3'b000,
        FT_MGMT = 3'b001,
        FT_DATA = 3'b010,
        FT_NULL = 3'b011
    } frame_type_t;

    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SEND = 1'b1
    } tx_state_t;

    typedef struct packed {
        logic [5:0]  hop;
        logic        bcast;
        logic [7:0]  tgt;
        logic [7:0]  src;
        logic        mcast;
        logic [13:0] len;
        logic [2:0]  prio;
        logic        cipher;
        logic        ts;
        logic [2:0]  ftype;
    } hdr_t;

    // Header fields to octets, octet zero in bits 7:0
    function automatic logic [79:0] pack_hdr(hdr_t h, logic [31:0] t);
        logic [15:0] w;
        w = {1'b0, h.mcast, h.len};
        return {t, h.hop, 1'b0, h.bcast, h.tgt, h.src, w[15:8], w[7:0],
                h.prio, h.cipher, h.ts, h.ftype};
    endfunction

    // Octets to header fields, reserved positions dropped
    function automatic hdr_t unpack_hdr(logic [79:0] b);
        hdr_t h;
        h.ftype  = b[2:0];
        h.ts     = b[3];
        h.cipher = b[4];
        h.prio   = b[7:5];
        h.len    = b[21:8];
        h.mcast  = b[22];
        h.src    = b[31:24];
        h.tgt    = b[39:32];
        h.bcast  = b[40];
        h.hop    = b[47:42];
        return h;
    endfunction

    // Rank of a user priority: zero sits above one and two
    function automatic logic [2:0] prio_rank(logic [2:0] p);
        if (p == 3'h0)
            return 3'h2;
        else if (p == 3'h1)
            return 3'h0;
        else if (p == 3'h2)
            return 3'h1;
        else
            return p;
    endfunction

endpackage

// ### logic/llc_frame_header_codec.sv
// Frame header builder, parser and relay with APB register access
module llc_frame_header_codec
    import llc_hdr_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic             pready_out,
    output logic      [31:0] prdata_out,
    output logic             pslverr_out,
    // Header octets toward the medium access logic
    output logic       [7:0] tx_data_out,
    output logic             tx_valid_out,
    output logic             tx_last_out,
    output logic             tx_cipher_next_out,
    input  wire logic        tx_ready_in,
    // Header octets from the medium access logic
    input  wire logic  [7:0] rx_data_in,
    input  wire logic        rx_valid_in,
    input  wire logic        rx_first_in,
    output logic             rx_done_out,
    // First byte of an application primitive arrives
    input  wire logic        adp_first_in
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic        relay_en_r, relay_en_nxt, inter_r, inter_nxt;
    hdr_t        cfg_r, cfg_nxt, rx_hdr_r, rx_hdr_nxt, relay_hdr_r, relay_hdr_nxt;
    logic [2:0]  thr_r, thr_nxt;
    logic        start_r, start_nxt, relay_pend_r, relay_pend_nxt;
    logic        rx_flag_r, rx_flag_nxt, drop_r, drop_nxt;
    tx_state_t   tx_state_r, tx_state_nxt;
    logic [79:0] tx_buf_r, tx_buf_nxt, rx_buf_r, rx_buf_nxt;
    logic [3:0]  tx_idx_r, tx_idx_nxt, tx_len_r, tx_len_nxt, rx_idx_r, rx_idx_nxt;
    logic [7:0]  tx_data_r, tx_data_nxt;
    logic        tx_valid_r, tx_valid_nxt, tx_last_r, tx_last_nxt;
    logic        tx_cipher_r, tx_cipher_nxt, tx_relay_r, tx_relay_nxt;
    logic        rx_done_r, rx_done_nxt, rx_busy_r, rx_busy_nxt;
    logic [32:0] now_half_r, now_half_nxt;
    logic [31:0] stamp_r, stamp_nxt, rx_time_r, rx_time_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        hdr_t        h;
        logic [79:0] rb;
        logic [3:0]  ni;
        logic        acc, wr;
        logic [31:0] st;
        h              = cfg_r;
        rb             = rx_buf_r;
        ni             = tx_idx_r + 4'h1;
        acc            = psel_in && penable_in && pready_r;
        wr             = acc && pwrite_in;
        pready_nxt     = psel_in && penable_in && !pready_r;
        pslverr_nxt    = 1'b0;
        prdata_nxt     = prdata_r;
        relay_en_nxt   = relay_en_r;
        inter_nxt      = inter_r;
        cfg_nxt        = cfg_r;
        thr_nxt        = thr_r;
        start_nxt      = start_r;
        rx_flag_nxt    = rx_flag_r;
        drop_nxt       = drop_r;
        relay_pend_nxt = relay_pend_r;
        relay_hdr_nxt  = relay_hdr_r;
        rx_hdr_nxt     = rx_hdr_r;
        rx_buf_nxt     = rx_buf_r;
        rx_idx_nxt     = rx_idx_r;
        rx_busy_nxt    = rx_busy_r;
        rx_done_nxt    = 1'b0;
        rx_time_nxt    = rx_time_r;
        tx_state_nxt   = tx_state_r;
        tx_buf_nxt     = tx_buf_r;
        tx_idx_nxt     = tx_idx_r;
        tx_len_nxt     = tx_len_r;
        tx_data_nxt    = tx_data_r;
        tx_valid_nxt   = tx_valid_r;
        tx_last_nxt    = tx_last_r;
        tx_cipher_nxt  = 1'b0;
        tx_relay_nxt   = tx_relay_r;
        now_half_nxt   = now_half_r + TS_HALF_STEP;
        stamp_nxt      = adp_first_in ? now_half_r[32:1] : stamp_r;
        st             = 32'h0;
        st[ST_BUSY]    = (tx_state_r == TX_SEND) || start_r || relay_pend_r;
        st[ST_RXDONE]  = rx_flag_r;
        st[ST_DROP]    = drop_r;
        st[ST_ABOVE]   = prio_rank(rx_hdr_r.prio) > prio_rank(thr_r);

        // Register reads, launched so that the data stands with pready
        if (pready_nxt && !pwrite_in)
        begin
            if (paddr_in == ADDR_CTRL)
                prdata_nxt = {29'h0, inter_r, relay_en_r, 1'b0};
            else if (paddr_in == ADDR_TXCFG)
                prdata_nxt = {2'h0, cfg_r.hop, cfg_r.bcast, cfg_r.mcast, cfg_r.len,
                              cfg_r.prio, cfg_r.cipher, cfg_r.ts, cfg_r.ftype};
            else if (paddr_in == ADDR_TXNODE)
                prdata_nxt = {16'h0, cfg_r.tgt, cfg_r.src};
            else if (paddr_in == ADDR_STATUS)
                prdata_nxt = st;
            else if (paddr_in == ADDR_RXCFG)
                prdata_nxt = {2'h0, rx_hdr_r.hop, rx_hdr_r.bcast, rx_hdr_r.mcast,
                              rx_hdr_r.len, rx_hdr_r.prio, rx_hdr_r.cipher,
                              rx_hdr_r.ts, rx_hdr_r.ftype};
            else if (paddr_in == ADDR_RXNODE)
                prdata_nxt = {16'h0, rx_hdr_r.tgt, rx_hdr_r.src};
            else if (paddr_in == ADDR_RXTIME)
                prdata_nxt = rx_time_r;
            else if (paddr_in == ADDR_THR)
                prdata_nxt = {29'h0, thr_r};
            else if (paddr_in == ADDR_NOW)
                prdata_nxt = now_half_r[32:1];
            else
            begin
                prdata_nxt  = 32'h0;
                pslverr_nxt = 1'b1;
            end
        end

        // Register writes; the done and drop status bits clear on writing one
        if (wr)
        begin
            if (paddr_in == ADDR_CTRL)
            begin
                start_nxt    = start_r || pwdata_in[CTRL_START];
                relay_en_nxt = pwdata_in[CTRL_RELAY];
                inter_nxt    = pwdata_in[CTRL_INTER];
            end
            else if (paddr_in == ADDR_TXCFG)
            begin
                cfg_nxt.ftype  = pwdata_in[2:0];
                cfg_nxt.ts     = pwdata_in[3];
                cfg_nxt.cipher = pwdata_in[4];
                cfg_nxt.prio   = pwdata_in[7:5];
                cfg_nxt.len    = pwdata_in[21:8];
                cfg_nxt.mcast  = pwdata_in[22];
                cfg_nxt.bcast  = pwdata_in[23];
                cfg_nxt.hop    = pwdata_in[29:24];
            end
            else if (paddr_in == ADDR_TXNODE)
            begin
                cfg_nxt.src = pwdata_in[7:0];
                cfg_nxt.tgt = pwdata_in[15:8];
            end
            else if (paddr_in == ADDR_STATUS)
            begin
                rx_flag_nxt = rx_flag_r && !pwdata_in[ST_RXDONE];
                drop_nxt    = drop_r && !pwdata_in[ST_DROP];
            end
            else if (paddr_in == ADDR_THR)
                thr_nxt = pwdata_in[2:0];
            else if (paddr_in == ADDR_NOW)
                now_half_nxt = {pwdata_in, 1'b0};
            else
                pslverr_nxt = 1'b0;
        end
        if (pready_nxt && !pwrite_in && paddr_in > ADDR_NOW)
            pslverr_nxt = 1'b1;

        // Receive parser; reserved positions are dropped by the unpack
        if (rx_valid_in && (rx_first_in || rx_busy_r))
        begin
            if (rx_first_in)
                rx_idx_nxt = 4'h0;
            else
                rx_idx_nxt = rx_idx_r;
            rb[{rx_idx_nxt, 3'b000} +: 8] = rx_data_in;
            rx_buf_nxt  = rb;
            rx_busy_nxt = 1'b1;
            if (rx_idx_nxt + 4'h1 == (rb[3] ? HDR_LONG_LEN : HDR_SHORT_LEN))
            begin
                rx_busy_nxt = 1'b0;
                rx_done_nxt = 1'b1;
                rx_hdr_nxt  = unpack_hdr(rb);
                rx_time_nxt = rb[3] ? rb[79:48] : 32'h0;
                rx_flag_nxt = 1'b1;
                if (relay_en_r)
                begin
                    if (rb[47:42] == 6'h00)
                        drop_nxt = 1'b1;
                    else if (!relay_pend_r)
                    begin
                        relay_pend_nxt = 1'b1;
                        relay_hdr_nxt  = unpack_hdr(rb);
                    end
                    else
                        drop_nxt = 1'b1;
                end
            end
            else
                rx_idx_nxt = rx_idx_nxt + 4'h1;
        end

        // Header fields of an originated frame
        if (cfg_r.ftype == FT_MGMT)
            h.prio = PRIO_MGMT;
        else if (cfg_r.ftype != FT_DATA)
            h.prio = PRIO_NONE;
        if (inter_r)
            h.src = SRC_INTER;

        // Transmit framer, relayed frames first
        case (tx_state_r)
            TX_IDLE:
            begin
                if (relay_pend_r || start_r)
                begin
                    if (relay_pend_r)
                    begin
                        h              = relay_hdr_r;
                        h.hop          = relay_hdr_r.hop - HOP_ONE;
                        relay_pend_nxt = 1'b0;
                        tx_buf_nxt     = pack_hdr(h, rx_time_r);
                    end
                    else
                    begin
                        start_nxt  = 1'b0;
                        tx_buf_nxt = pack_hdr(h, stamp_r);
                    end
                    tx_relay_nxt = relay_pend_r;
                    tx_len_nxt   = h.ts ? HDR_LONG_LEN : HDR_SHORT_LEN;
                    tx_idx_nxt   = 4'h0;
                    tx_data_nxt  = tx_buf_nxt[7:0];
                    tx_valid_nxt = 1'b1;
                    tx_last_nxt  = 1'b0;
                    tx_state_nxt = TX_SEND;
                end
            end
            TX_SEND:
            begin
                if (tx_ready_in)
                begin
                    if (tx_last_r)
                    begin
                        tx_valid_nxt  = 1'b0;
                        tx_last_nxt   = 1'b0;
                        tx_cipher_nxt = tx_buf_r[4];
                        tx_state_nxt  = TX_IDLE;
                    end
                    else
                    begin
                        tx_idx_nxt  = ni;
                        tx_data_nxt = tx_buf_r[{ni, 3'b000} +: 8];
                        tx_last_nxt = (ni == tx_len_r - 4'h1);
                    end
                end
            end
            default:
                tx_state_nxt = TX_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pready_r     <= 1'b0;
            pslverr_r    <= 1'b0;
            prdata_r     <= 32'h0;
            relay_en_r   <= 1'b0;
            inter_r      <= 1'b0;
            cfg_r        <= '0;
            rx_hdr_r     <= '0;
            relay_hdr_r  <= '0;
            thr_r        <= 3'h0;
            start_r      <= 1'b0;
            relay_pend_r <= 1'b0;
            rx_flag_r    <= 1'b0;
            drop_r       <= 1'b0;
            tx_state_r   <= TX_IDLE;
            tx_buf_r     <= 80'h0;
            rx_buf_r     <= 80'h0;
            tx_idx_r     <= 4'h0;
            tx_len_r     <= HDR_SHORT_LEN;
            rx_idx_r     <= 4'h0;
            tx_data_r    <= 8'h00;
            tx_valid_r   <= 1'b0;
            tx_last_r    <= 1'b0;
            tx_cipher_r  <= 1'b0;
            tx_relay_r   <= 1'b0;
            rx_done_r    <= 1'b0;
            rx_busy_r    <= 1'b0;
            now_half_r   <= 33'h0;
            stamp_r      <= 32'h0;
            rx_time_r    <= 32'h0;
        end
        else
        begin
            pready_r     <= pready_nxt;
            pslverr_r    <= pslverr_nxt;
            prdata_r     <= prdata_nxt;
            relay_en_r   <= relay_en_nxt;
            inter_r      <= inter_nxt;
            cfg_r        <= cfg_nxt;
            rx_hdr_r     <= rx_hdr_nxt;
            relay_hdr_r  <= relay_hdr_nxt;
            thr_r        <= thr_nxt;
            start_r      <= start_nxt;
            relay_pend_r <= relay_pend_nxt;
            rx_flag_r    <= rx_flag_nxt;
            drop_r       <= drop_nxt;
            tx_state_r   <= tx_state_nxt;
            tx_buf_r     <= tx_buf_nxt;
            rx_buf_r     <= rx_buf_nxt;
            tx_idx_r     <= tx_idx_nxt;
            tx_len_r     <= tx_len_nxt;
            rx_idx_r     <= rx_idx_nxt;
            tx_data_r    <= tx_data_nxt;
            tx_valid_r   <= tx_valid_nxt;
            tx_last_r    <= tx_last_nxt;
            tx_cipher_r  <= tx_cipher_nxt;
            tx_relay_r   <= tx_relay_nxt;
            rx_done_r    <= rx_done_nxt;
            rx_busy_r    <= rx_busy_nxt;
            now_half_r   <= now_half_nxt;
            stamp_r      <= stamp_nxt;
            rx_time_r    <= rx_time_nxt;
        end
    end

    assign pready_out         = pready_r;
    assign pslverr_out        = pslverr_r;
    assign prdata_out         = prdata_r;
    assign tx_data_out        = tx_data_r;
    assign tx_valid_out       = tx_valid_r;
    assign tx_last_out        = tx_last_r;
    assign tx_cipher_next_out = tx_cipher_r;
    assign rx_done_out        = rx_done_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);

    hdr_len_a: assert property (tx_valid_out && tx_last_out |->
        tx_idx_r == tx_len_r - 4'h1 && (tx_len_r == HDR_SHORT_LEN || tx_len_r == HDR_LONG_LEN))
        else $error("header length wrong");
    first_octet_a: assert property ($rose(tx_valid_out) |-> tx_idx_r == 4'h0
        ##1 (tx_idx_r == ($past(tx_ready_in) ? 4'h1 : 4'h0)))
        else $error("octets out of order");
    ts_flag_a: assert property (tx_valid_out && tx_idx_r == 4'h0 |->
        tx_data_out[3] == (tx_len_r == HDR_LONG_LEN))
        else $error("timestamp flag and length disagree");
    mgmt_prio_a: assert property (tx_valid_out && tx_idx_r == 4'h0 && !tx_relay_r &&
        tx_data_out[2:0] == FT_MGMT |-> tx_data_out[7:5] == PRIO_MGMT)
        else $error("management priority not seven");
    rsvd_zero_a: assert property (tx_valid_out && (tx_idx_r == 4'h2 || tx_idx_r == 4'h5) |->
        (tx_idx_r == 4'h2 ? !tx_data_out[7] : !tx_data_out[1]))
        else $error("reserved bit sent nonzero");
    inter_src_a: assert property (tx_valid_out && tx_idx_r == 4'h3 && !tx_relay_r &&
        inter_r && $stable(inter_r) |-> tx_data_out == SRC_INTER)
        else $error("cross-domain source wrong");
    relay_keep_a: assert property (tx_valid_out && tx_relay_r && tx_idx_r == 4'h0 |->
        tx_data_out[7:5] == relay_hdr_r.prio)
        else $error("relay changed priority");
    hop_dec_a: assert property (tx_valid_out && tx_relay_r && tx_idx_r == 4'h5 |->
        tx_data_out[7:2] == relay_hdr_r.hop - HOP_ONE)
        else $error("hop limit not decremented");
    no_fwd_a: assert property (rx_done_out && relay_en_r && rx_hdr_r.hop == 6'h00 &&
        $past(!relay_pend_r) |-> !relay_pend_r && drop_r)
        else $error("zero hop frame relayed");
    stamp_a: assert property (adp_first_in |=> stamp_r == $past(now_half_r[32:1]))
        else $error("arrival time not captured");
    cipher_a: assert property (tx_valid_out && tx_last_out && tx_ready_in |=>
        tx_cipher_next_out == tx_buf_r[4])
        else $error("cipher follow-up wrong");

    long_hdr_c: cover property (tx_valid_out && tx_last_out && tx_len_r == HDR_LONG_LEN);
    relay_c: cover property (tx_valid_out && tx_relay_r && tx_last_out);
    drop_c: cover property ($rose(drop_r));
    stall_c: cover property (tx_valid_out && !tx_ready_in [*3]);

endmodule // llc_frame_header_codec

// ### bench/mac_sink_model.sv
// Medium access sink model: takes header octets, stalls on request
module mac_sink_model
    import llc_hdr_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    // Header octet stream
    input  wire logic [7:0] tx_data_in,
    input  wire logic       tx_valid_in,
    input  wire logic       tx_last_in,
    input  wire logic       tx_cipher_next_in,
    input  wire logic       stall_in,
    output logic            tx_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] oct [0:9];
    int         pos;
    int         len;
    int         nfr;
    logic       cip;
    always_ff @(posedge mclk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tx_ready_out <= 1'b0;
            pos <= 0;
            len <= 0;
            nfr <= 0;
            cip <= 1'b0;
        end
        else
        begin
            // Stalling alternates ready so the framer must hold its octet
            tx_ready_out <= stall_in ? ~tx_ready_out : 1'b1;
            if (tx_valid_in && tx_ready_out)
            begin
                if (pos < 10)
                    oct[pos] <= tx_data_in;
                pos <= tx_last_in ? 0 : pos + 1;
                if (pos == 0)
                    cip <= 1'b0;
                if (tx_last_in)
                begin
                    len <= pos + 1;
                    nfr <= nfr + 1;
                end
            end
            if (tx_cipher_next_in)
                cip <= 1'b1;
        end
    end
endmodule // mac_sink_model

// ### bench/tb_llc_frame_header_codec.sv
// Testbench of the frame header codec: origination, relay and registers
module tb_llc_frame_header_codec;
    import llc_hdr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0, resetn_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, e, tx_valid, tx_last, tx_cip, tx_ready, rx_done, stall = 1'b0;
    logic [7:0] tx_data, rx_data = 8'h00;
    logic rx_valid = 1'b0, rx_first = 1'b0, adp_first = 1'b0;
    int mismatches = 0, cmp_count = 0, cyc = 0, n0;
    logic [7:0] o0;
    always #12.5 mclk_in = ~mclk_in;
    llc_frame_header_codec u_llc_frame_header_codec (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
        .tx_data_out(tx_data), .tx_valid_out(tx_valid), .tx_last_out(tx_last),
        .tx_cipher_next_out(tx_cip), .tx_ready_in(tx_ready), .rx_data_in(rx_data),
        .rx_valid_in(rx_valid), .rx_first_in(rx_first), .rx_done_out(rx_done),
        .adp_first_in(adp_first));
    mac_sink_model u_mac_sink_model (.mclk_in(mclk_in), .resetn_in(resetn_in),
        .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_last_in(tx_last),
        .tx_cipher_next_in(tx_cip), .stall_in(stall), .tx_ready_out(tx_ready));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        do @(posedge mclk_in); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_frame();
        while (u_mac_sink_model.nfr == n0)
            @(posedge mclk_in);
        repeat (3) @(posedge mclk_in);
    endtask
    task automatic send(input logic [31:0] cfg, input logic [31:0] node, input logic [2:0] ctl);
        apb(1'b1, ADDR_TXCFG, cfg);
        apb(1'b1, ADDR_TXNODE, node);
        n0 = u_mac_sink_model.nfr;
        apb(1'b1, ADDR_CTRL, {29'h0, ctl});
        wait_frame();
    endtask
    task automatic rx_send(input logic [47:0] h);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge mclk_in);
            rx_valid <= 1'b1; rx_first <= (i == 0); rx_data <= h[8*i +: 8];
        end
        @(posedge mclk_in);
        rx_valid <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_layout();
        stall <= 1'b1;
        send({2'h0, 6'h2a, 1'b1, 1'b1, 14'h1234, 3'h5, 2'b00, 3'h2}, 32'h9c21, 3'b001);
        stall <= 1'b0;
        chk("hdr_len", 6, u_mac_sink_model.len);
        chk("oct0", 8'ha2, u_mac_sink_model.oct[0]);
        chk("oct12", 16'h5234, {u_mac_sink_model.oct[2], u_mac_sink_model.oct[1]});
        chk("oct34", 16'h9c21, {u_mac_sink_model.oct[4], u_mac_sink_model.oct[3]});
        chk("oct5", 8'ha9, u_mac_sink_model.oct[5]);
    endtask
    task automatic t_types();
        logic [2:0] pe [4] = '{3'h0, 3'h7, 3'h5, 3'h0};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, ADDR_NOW, 32'h1234abcd + i);
            adp_first <= 1'b1;
            @(posedge mclk_in);
            adp_first <= 1'b0;
            send({2'h0, 6'h05, 2'b00, 14'h0010, 3'h5, i[1], i[0], i[2:0]}, 32'h0044, 3'b101);
            o0 = {pe[i], i[1], i[0], i[2:0]};
            chk("type_oct0", o0, u_mac_sink_model.oct[0]);
            chk("ts_len", i[0] ? 10 : 6, u_mac_sink_model.len);
            chk("cipher_pulse", i[1], u_mac_sink_model.cip);
            chk("inter_src", 8'hfb, u_mac_sink_model.oct[3]);
            q = {u_mac_sink_model.oct[9], u_mac_sink_model.oct[8],
                 u_mac_sink_model.oct[7], u_mac_sink_model.oct[6]};
            if (i[0])
                chk("stamp", 32'h1234abcd + i, q);
        end
    endtask
    task automatic t_relay();
        apb(1'b1, ADDR_CTRL, 32'h2);
        n0 = u_mac_sink_model.nfr;
        rx_send({6'h03, 2'b11, 8'h77, 8'h33, 8'hc5, 8'h10, 8'h82});
        @(posedge mclk_in);
        chk("rx_done", 1'b1, rx_done);
        wait_frame();
        chk("relay_oct0", 8'h82, u_mac_sink_model.oct[0]);
        chk("relay_rsvd", 8'h45, u_mac_sink_model.oct[2]);
        chk("relay_src", 8'h33, u_mac_sink_model.oct[3]);
        chk("relay_hop", 8'h09, u_mac_sink_model.oct[5]);
        apb(1'b0, ADDR_RXCFG, 32'h0);
        chk("rx_cfg", 32'h03c51082, q);
        n0 = u_mac_sink_model.nfr;
        rx_send({6'h00, 2'b01, 8'h77, 8'h33, 8'h05, 8'h10, 8'h22});
        repeat (20) @(posedge mclk_in);
        chk("no_relay", n0, u_mac_sink_model.nfr);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("drop_bit", 1'b1, q[ST_DROP]);
        chk("above_thr", 1'b0, q[ST_ABOVE]);
        apb(1'b0, 12'h030, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, q);
    endtask
    initial
    begin
        repeat (10) @(posedge mclk_in);
        resetn_in <= 1'b1;
        t_layout();
        t_types();
        t_relay();
        tally_and_finish();
    end
endmodule // tb_llc_frame_header_codec
